// file: hdl/lmrd_defines.vh
`ifndef LMRD_DEFINES_VH
`define LMRD_DEFINES_VH

// Opcode patterns and masks, 12-bit instruction word
`define LMRD_OP_NOP        12'h000
`define LMRD_OP_OPTION     12'h002
`define LMRD_MASK_STORE    12'hfe0
`define LMRD_OP_STORE      12'h020
`define LMRD_MASK_LIT      12'hf00
`define LMRD_OP_LOAD_LIT   12'hc00
`define LMRD_OP_RET_LIT    12'h800

// Field positions
`define LMRD_FILE_MSB      4
`define LMRD_LIT_MSB       7

// Reset values
`define LMRD_W_RST         8'h00
`define LMRD_OPTION_RST    8'hff
`define LMRD_PC_RST        12'h000

// Cycles taken by the literal return
`define LMRD_RET_CYCLES    2

`endif

// file: hdl/lmrd_opcode_match.v
`timescale 1ns/1ps
`include "lmrd_defines.vh"

module lmrd_opcode_match (
  instr,
  is_nop,
  is_option,
  is_store,
  is_load_lit,
  is_ret_lit
);
  input  wire [11:0] instr;
  output wire        is_nop;
  output wire        is_option;
  output wire        is_store;
  output wire        is_load_lit;
  output wire        is_ret_lit;

  assign is_nop      = (instr == `LMRD_OP_NOP);
  assign is_option   = (instr == `LMRD_OP_OPTION);
  assign is_store    = ((instr & `LMRD_MASK_STORE) == `LMRD_OP_STORE);
  assign is_load_lit = ((instr & `LMRD_MASK_LIT) == `LMRD_OP_LOAD_LIT);
  assign is_ret_lit  = ((instr & `LMRD_MASK_LIT) == `LMRD_OP_RET_LIT);
endmodule

// file: hdl/lmrd_decode.v
`timescale 1ns/1ps
`include "lmrd_defines.vh"

// Overview of operation
// - store_work_to_file writes work into selected file
// - Option opcode copies work into option register
// - return_with_literal loads literal into work
// - Return pops stack_top_entry into program counter
// - Return takes two cycles, next fetch discarded
module lmrd_decode #(
  parameter PC_W = 12
) (
  clk_sys,
  rst_n,
  instr,
  instr_valid,
  stack_top_entry,
  pc,
  pc_load,
  stack_pop,
  fetch_flush,
  work_reg,
  option_reg,
  file_addr,
  file_wdata,
  file_we,
  status_we,
  known_op
);
  input  wire            clk_sys;
  input  wire            rst_n;
  input  wire [11:0]     instr;
  input  wire            instr_valid;
  input  wire [PC_W-1:0] stack_top_entry;
  output reg  [PC_W-1:0] pc;
  output wire            pc_load;
  output wire            stack_pop;
  output wire            fetch_flush;
  output reg  [7:0]      work_reg;
  output reg  [7:0]      option_reg;
  output reg  [4:0]      file_addr;
  output reg  [7:0]      file_wdata;
  output reg             file_we;
  output wire            status_we;
  output wire            known_op;

  ////////////////////////////////////////////////////////////////////////
  localparam ST_RUN   = 1'b0;
  localparam ST_FLUSH = 1'b1;

  // Counter step held at the counter's own width
  localparam [PC_W-1:0] PC_STEP = {{(PC_W-1){1'b0}}, 1'b1};

  reg             state_reg;
  reg             state_next;
  reg  [PC_W-1:0] pc_next;
  reg  [7:0]      work_next;
  reg  [7:0]      option_next;
  reg             file_we_next;
  reg  [4:0]      file_addr_next;
  reg  [7:0]      file_wdata_next;
  wire            is_nop;
  wire            is_option;
  wire            is_store;
  wire            is_load_lit;
  wire            is_ret_lit;
  wire            exec;
  wire            ret_taken;
  wire [7:0]      lit_field;
  wire [4:0]      file_field;

  ////////////////////////////////////////////////////////////////////////
  // Pattern matching kept apart from sequencing
  lmrd_opcode_match u_match (
    .instr       (instr),
    .is_nop      (is_nop),
    .is_option   (is_option),
    .is_store    (is_store),
    .is_load_lit (is_load_lit),
    .is_ret_lit  (is_ret_lit)
  );

  assign lit_field  = instr[`LMRD_LIT_MSB:0];
  assign file_field = instr[`LMRD_FILE_MSB:0];

  ////////////////////////////////////////////////////////////////////////
  // Word fetched during the flush slot is thrown away
  assign exec        = instr_valid && (state_reg == ST_RUN);
  assign ret_taken   = exec && is_ret_lit;
  assign stack_pop   = ret_taken;
  assign pc_load     = ret_taken;
  assign fetch_flush = (state_reg == ST_FLUSH);
  // None of these instructions touches status
  assign status_we   = 1'b0;
  // Unlisted words only advance the counter
  assign known_op    = is_nop | is_option | is_store | is_load_lit | is_ret_lit;

  ////////////////////////////////////////////////////////////////////////
  // One state bit, no cycle counter: only a single slot is ever dropped
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_RUN: begin
        if (ret_taken) begin
          state_next = ST_FLUSH;
        end
      end
      ST_FLUSH: begin
        // Slot stretches while the fetch stalls
        if (instr_valid) begin
          state_next = ST_RUN;
        end
      end
      default: begin
        state_next = ST_RUN;
      end
    endcase
  end

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      state_reg <= ST_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Return target comes straight from the stack top
  always @* begin
    pc_next = pc;
    if (ret_taken) begin
      pc_next = stack_top_entry;
    end else if (instr_valid) begin
      // Discarded slot still advances past the fetched word
      pc_next = pc + PC_STEP;
    end
  end

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      pc <= `LMRD_PC_RST;
    end else begin
      pc <= pc_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Both literal forms share the low byte of the word
  always @* begin
    work_next = work_reg;
    if (exec && is_load_lit) begin
      work_next = lit_field;
    end
    if (ret_taken) begin
      work_next = lit_field;
    end
  end

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      work_reg <= `LMRD_W_RST;
    end else begin
      work_reg <= work_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Option takes the work value held before the edge
  always @* begin
    option_next = option_reg;
    if (exec && is_option) begin
      option_next = work_reg;
    end
  end

  // Reset leaves every option bit set
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      option_reg <= `LMRD_OPTION_RST;
    end else begin
      option_reg <= option_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registered write port; address and data hold between strobes
  always @* begin
    file_we_next    = 1'b0;
    file_addr_next  = file_addr;
    file_wdata_next = file_wdata;
    if (exec && is_store) begin
      file_we_next    = 1'b1;
      file_addr_next  = file_field;
      file_wdata_next = work_reg;
    end
  end

  // Strobe lasts exactly one cycle per taken store
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      file_we <= 1'b0;
    end else begin
      file_we <= file_we_next;
    end
  end

  // Cleared at reset so the file bus is quiet before the first store
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      file_addr  <= 5'h00;
      file_wdata <= 8'h00;
    end else begin
      file_addr  <= file_addr_next;
      file_wdata <= file_wdata_next;
    end
  end
endmodule

// file: verif/lmrd_props.sv
`timescale 1ns/1ps
module lmrd_props #(parameter PC_W = 12) (
  input wire            clk_sys,
  input wire            rst_n,
  input wire [11:0]     instr,
  input wire            instr_valid,
  input wire [PC_W-1:0] stack_top_entry,
  input wire [PC_W-1:0] pc,
  input wire            stack_pop,
  input wire            fetch_flush,
  input wire [7:0]      work_reg,
  input wire [7:0]      option_reg,
  input wire [4:0]      file_addr,
  input wire [7:0]      file_wdata,
  input wire            file_we,
  input wire            status_we
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  wire tk = instr_valid && !fetch_flush;
  sequence s_ret; tk && instr[11:8] == 4'h8; endsequence
  sequence s_drop; instr_valid && fetch_flush; endsequence
  a_store_file: assert property (tk && instr[11:5] == 7'h01 |=> file_we && file_wdata == $past(work_reg)
    && file_addr == $past(instr[4:0]))
    else $error("bad store");
  a_flush_drop: assert property (s_drop |-> !stack_pop ##1 (!fetch_flush && !file_we
    && work_reg == $past(work_reg)))
    else $error("discarded word acted");
  a_nop_idle: assert property (tk && instr == 12'h000 |=> work_reg == $past(work_reg) && !file_we
    && pc == $past(pc) + {{(PC_W-1){1'b0}}, 1'b1})
    else $error("bad no-op");
  a_option_copy: assert property (tk && instr == 12'h002 |=> option_reg == $past(work_reg))
    else $error("bad option");
  a_ret_work: assert property (s_ret |=> work_reg == $past(instr[7:0]))
    else $error("bad return work");
  a_ret_pop: assert property (s_ret |-> stack_pop ##1 pc == $past(stack_top_entry))
    else $error("bad return pc");
  a_ret_flush: assert property (s_ret |=> fetch_flush)
    else $error("no discard slot");
  a_load_work: assert property (tk && instr[11:8] == 4'hc |=> work_reg == $past(instr[7:0]))
    else $error("bad load");
  a_status_kept: assert property (!status_we)
    else $error("status written");
endmodule
bind lmrd_decode lmrd_props #(.PC_W(PC_W)) u_props (.clk_sys, .rst_n, .instr, .instr_valid, .stack_top_entry,
  .pc, .stack_pop, .fetch_flush, .work_reg, .option_reg, .file_addr, .file_wdata, .file_we, .status_we);

// file: verif/lmrd_stack_model.sv
`timescale 1ns/1ps
module lmrd_stack_model (
  input  wire         clk_sys,
  input  wire         stack_pop,
  output wire  [11:0] stack_top_entry
);
  // Next entry differs so a missed pop shows
  logic popped = 1'b0;
  assign stack_top_entry = popped ? 12'h155 : 12'h3c4;
  always @(posedge clk_sys) begin
    if (stack_pop) begin
      popped <= 1'b1;
    end
  end
endmodule

// file: verif/literal_move_return_decode_tb_top.sv
`timescale 1ns/1ps
module literal_move_return_decode_tb_top;
  logic        clk_sys = 0, rst_n = 0, instr_valid = 0;
  logic [11:0] instr = 12'h000, stack_top_entry, pc;
  logic [7:0]  work_reg, option_reg, file_wdata;
  logic [4:0]  file_addr;
  logic        pc_load, stack_pop, fetch_flush, file_we, status_we, known_op;
  logic        seen_known, seen_load, seen_pop;
  int          n_fail = 0, cmp_count = 0;
  always #12.5 clk_sys = ~clk_sys;
  lmrd_decode u_dut (.clk_sys, .rst_n, .instr, .instr_valid, .stack_top_entry, .pc, .pc_load, .stack_pop,
    .fetch_flush, .work_reg, .option_reg, .file_addr, .file_wdata, .file_we, .status_we, .known_op);
  lmrd_stack_model u_stk (.clk_sys, .stack_pop, .stack_top_entry);
  //////////////////////////////////////////////////////////////////////////////
  task chk(string n, logic [11:0] e, logic [11:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask
  task final_report;
    if (n_fail == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task issue(logic [11:0] w);
    @(negedge clk_sys);
    instr = w;
    instr_valid = 1;
    #2;
    seen_known = known_op;
    seen_load = pc_load;
    seen_pop = stack_pop;
    @(negedge clk_sys);
    instr_valid = 0;
  endtask
  task t_load_nop;
    issue(12'hc5a);
    chk("work", 12'h05a, work_reg);
    chk("known", 12'h001, seen_known);
    issue(12'h000);
    chk("pc", 12'h002, pc);
    chk("work", 12'h05a, work_reg);
    chk("known", 12'h001, seen_known);
    issue(12'h0ff);
    chk("known", 12'h000, seen_known);
    chk("pc", 12'h003, pc);
    chk("work", 12'h05a, work_reg);
  endtask
  task t_store_option;
    issue(12'h03f);
    chk("we", 12'h001, file_we);
    chk("addr", 12'h01f, file_addr);
    chk("wdata", 12'h05a, file_wdata);
    chk("load", 12'h000, seen_load);
    issue(12'h002);
    chk("option", 12'h05a, option_reg);
    chk("we", 12'h000, file_we);
  endtask
  task t_return;
    issue(12'h8a7);
    chk("pc", 12'h3c4, pc);
    chk("work", 12'h0a7, work_reg);
    chk("flush", 12'h001, fetch_flush);
    chk("load", 12'h001, seen_load);
    chk("pop", 12'h001, seen_pop);
    issue(12'hc11);
    chk("work", 12'h0a7, work_reg);
    chk("pc", 12'h3c5, pc);
    chk("pop", 12'h000, seen_pop);
    chk("flush", 12'h000, fetch_flush);
    issue(12'hc33);
    chk("work", 12'h033, work_reg);
    chk("pc", 12'h3c6, pc);
  endtask
  initial begin
    repeat (20) @(negedge clk_sys);
    rst_n = 1;
    chk("option", 12'h0ff, option_reg);
    t_load_nop;
    t_store_option;
    t_return;
    final_report;
  end
endmodule
